// >>> core/ascp_serial_port.sv
// serial configuration port with mode register bank and output formatting
// assumes the host masters SCK/CS_N; SCK may stop between transfers
`timescale 1ns/1ns

module ascp_serial_port
  (
    input  wire logic                CLK_SYS_I,
    input  wire logic                RST_I,
    input  wire logic                SCK_I,
    input  wire logic                CS_N_I,
    input  wire logic                SDI_I,
    input  wire logic                SDO_I,
    output logic                     SDO_O,
    output logic                     SDO_OE_O,
    input  wire logic                PARALLEL_SERIAL_SELECT_I,
    input  wire logic [15:0]         CH1_SAMPLE_I,
    input  wire logic [15:0]         CH2_SAMPLE_I,
    output ascp_pkg::ascp_cfg_s      CFG_O,
    output logic                     CORE_SLEEP_O,
    output logic                     CH1_VALID_O,
    output logic                     CH2_VALID_O,
    output logic [15:0]              CH1_DATA_O,
    output logic [15:0]              CH2_DATA_O,
    output logic [7:0]               DRIVER_CURRENT_O
  );
  import ascp_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // register read mux; reset and unmapped addresses read a fixed value
  function automatic logic [7:0] reg_read(input ascp_bank_s b, input logic [6:0] a);
    logic [7:0] v;
    v = READ_UNMAPPED;
    case (a)
      ADDR_FMT:    v = b.fmt;
      ADDR_OUT:    v = b.outc;
      ADDR_PAT_HI: v = b.pat_hi;
      ADDR_PAT_LO: v = b.pat_lo;
      default:     v = READ_UNMAPPED;
    endcase
    return v;
  endfunction

  // coding, scrambling, then pattern override last so it wins
  function automatic logic [15:0] fmt_sample(input logic [15:0] s, input ascp_cfg_s c);
    logic [15:0] v;
    v = s;
    if (c.signed_format_select)
    begin
      v[15] = ~v[15];
    end
    if (c.output_scramble_enable)
    begin
      v[15:1] = v[15:1] ^ {15{v[0]}};
    end
    if (c.pattern_force_enable)
    begin
      v = {c.pattern_high_byte, c.pattern_low_byte};
    end
    return v;
  endfunction

  // driver current; unused code 011 falls back to the default level
  function automatic logic [7:0] drv_current(input logic [2:0] code, input logic term);
    logic [7:0] v;
    v = CUR_3P5;
    case (code)
      3'h0:    v = CUR_3P5;
      3'h1:    v = CUR_4P0;
      3'h2:    v = CUR_4P5;
      3'h4:    v = CUR_3P0;
      3'h5:    v = CUR_2P5;
      3'h6:    v = CUR_2P1;
      3'h7:    v = CUR_1P75;
      default: v = CUR_3P5;
    endcase
    if (term)
    begin
      v = {v[6:0], 1'b0};
    end
    return v;
  endfunction

  // wake-up counter: reloads while the channel is down
  function automatic logic [6:0] nap_step(input logic [6:0] cnt, input logic down);
    logic [6:0] v;
    v = cnt;
    if (down)
    begin
      v = NAP_WAKE_CYC;
    end
    else if (cnt != 7'h00)
    begin
      v = cnt - 7'h01;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // link domain: frame shifter
  // ---------------------------------------------------------------
  ascp_frame_s frame_reg;
  ascp_frame_s frame_next;
  ascp_bank_s  bank_reg;
  ascp_bank_s  bank_next;
  ascp_sys_s   sys_reg;
  ascp_sys_s   sys_next;
  logic        frame_rst;

  // cs high clears the frame asynchronously since sck stops outside frames
  assign frame_rst = RST_I | CS_N_I;

  // bit counter saturates at sixteen, so extra edges do nothing
  always_comb
  begin
    logic [7:0] rd;
    rd = reg_read(bank_reg, {frame_reg.shreg[5:0], SDI_I});
    frame_next = frame_reg;
    frame_next.sdo_lvl = 1'b0;
    if (frame_reg.cnt != WORD_DONE_CNT)
    begin
      frame_next.cnt = frame_reg.cnt + 5'h01;
      frame_next.shreg = {frame_reg.shreg[13:0], SDI_I};
    end
    if (frame_reg.cnt == FIRST_BIT_CNT)
    begin
      frame_next.is_read = SDI_I;
    end
    // read data goes out msb first after the address is complete
    if (frame_reg.is_read && frame_reg.cnt == ADDR_DONE_CNT)
    begin
      frame_next.rd_sh = {rd[6:0], 1'b0};
      frame_next.sdo_oe = ~rd[7];
    end
    else if (frame_reg.is_read && frame_reg.cnt > ADDR_DONE_CNT
             && frame_reg.cnt <= RD_LAST_CNT)
    begin
      frame_next.rd_sh = {frame_reg.rd_sh[6:0], 1'b0};
      frame_next.sdo_oe = ~frame_reg.rd_sh[7];
    end
    else
    begin
      frame_next.sdo_oe = 1'b0;
    end
  end

  // frame register, cleared by reset or chip select high
  always_ff @(posedge SCK_I or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      frame_reg <= '0;
    end
    else
    begin
      frame_reg <= frame_next;
    end
  end

  // ---------------------------------------------------------------
  // link domain: register bank
  // ---------------------------------------------------------------

  // commit only on the sixteenth edge; a short frame never gets here
  always_comb
  begin
    logic [15:0] word;
    word = {frame_reg.shreg, SDI_I};
    bank_next = bank_reg;
    if (frame_reg.cnt == LAST_BIT_CNT && !word[RW_POS])
    begin
      bank_next.upd_tgl = ~bank_reg.upd_tgl;
      case (word[ADDR_MSB:ADDR_LSB])
        ADDR_RESET:
        begin
          // reset bit is never stored, so it reads back as clear
          if (word[SRST_BIT])
          begin
            bank_next.fmt = REG_RESET_VAL;
            bank_next.outc = REG_RESET_VAL;
            bank_next.pat_hi = REG_RESET_VAL;
            bank_next.pat_lo = REG_RESET_VAL;
            bank_next.srst_tgl = ~bank_reg.srst_tgl;
          end
        end
        ADDR_FMT:    bank_next.fmt = word[7:0];
        ADDR_OUT:    bank_next.outc = word[7:0];
        ADDR_PAT_HI: bank_next.pat_hi = word[7:0];
        ADDR_PAT_LO: bank_next.pat_lo = word[7:0];
        default:     bank_next.upd_tgl = bank_reg.upd_tgl;
      endcase
    end
  end

  // bank register; held between writes so the system side can sample it
  always_ff @(posedge SCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      bank_reg <= '0;
    end
    else
    begin
      bank_reg <= bank_next;
    end
  end

  // ---------------------------------------------------------------
  // system domain
  // ---------------------------------------------------------------

  // toggles cross by two flops; bank words are stable for a whole frame
  always_comb
  begin
    logic down1;
    logic down2;
    down1 = 1'b0;
    down2 = 1'b0;
    sys_next = sys_reg;
    sys_next.sel_s1 = PARALLEL_SERIAL_SELECT_I;
    sys_next.sel_s2 = sys_reg.sel_s1;
    sys_next.upd_s1 = bank_reg.upd_tgl;
    sys_next.upd_s2 = sys_reg.upd_s1;
    sys_next.upd_s3 = sys_reg.upd_s2;
    sys_next.rst_s1 = bank_reg.srst_tgl;
    sys_next.rst_s2 = sys_reg.rst_s1;
    sys_next.rst_s3 = sys_reg.rst_s2;
    // updates while the select pin is high are not serial writes
    if (sys_reg.upd_s2 != sys_reg.upd_s3 && !sys_reg.sel_s2)
    begin
      sys_next.cfg.duty_stabilizer_off = bank_reg.fmt[FMT_DCS_OFF_BIT];
      sys_next.cfg.output_scramble_enable = bank_reg.fmt[FMT_SCRAMBLE_BIT];
      sys_next.cfg.signed_format_select = bank_reg.fmt[FMT_SIGNED_BIT];
      sys_next.cfg.sleep_req = bank_reg.fmt[FMT_SLEEP_BIT];
      sys_next.cfg.nap_ch2 = bank_reg.fmt[FMT_NAP2_BIT] & ~bank_reg.fmt[FMT_SLEEP_BIT];
      sys_next.cfg.nap_ch1 = bank_reg.fmt[FMT_NAP1_BIT] & ~bank_reg.fmt[FMT_SLEEP_BIT];
      sys_next.cfg.driver_current_code = bank_reg.outc[OUT_CUR_MSB:OUT_CUR_LSB];
      sys_next.cfg.internal_term_enable = bank_reg.outc[OUT_TERM_BIT];
      sys_next.cfg.output_drivers_off = bank_reg.outc[OUT_OFF_BIT];
      sys_next.cfg.pattern_force_enable = bank_reg.outc[OUT_TEST_BIT];
      sys_next.cfg.lane_count_select = bank_reg.outc[OUT_LANE_MSB:OUT_LANE_LSB];
      sys_next.cfg.pattern_high_byte = bank_reg.pat_hi;
      sys_next.cfg.pattern_low_byte = bank_reg.pat_lo;
    end
    // momentary sleep after a software reset
    if (sys_reg.rst_s2 != sys_reg.rst_s3)
    begin
      sys_next.sleep_cnt = SRST_SLEEP_CYC;
    end
    else if (sys_reg.sleep_cnt != 8'h00)
    begin
      sys_next.sleep_cnt = sys_reg.sleep_cnt - 8'h01;
    end
    sys_next.core_sleep = sys_next.cfg.sleep_req | (sys_next.sleep_cnt != 8'h00);
    // channels stay invalid until the wake-up count runs out
    down1 = sys_reg.cfg.nap_ch1 | sys_reg.core_sleep;
    down2 = sys_reg.cfg.nap_ch2 | sys_reg.core_sleep;
    sys_next.nap1_cnt = nap_step(sys_reg.nap1_cnt, down1);
    sys_next.nap2_cnt = nap_step(sys_reg.nap2_cnt, down2);
    sys_next.ch1_valid = ~down1 & (sys_next.nap1_cnt == 7'h00);
    sys_next.ch2_valid = ~down2 & (sys_next.nap2_cnt == 7'h00);
    sys_next.ch1_data = fmt_sample(CH1_SAMPLE_I, sys_reg.cfg);
    sys_next.ch2_data = fmt_sample(CH2_SAMPLE_I, sys_reg.cfg);
    sys_next.drv_cur = drv_current(sys_reg.cfg.driver_current_code,
                                   sys_reg.cfg.internal_term_enable);
  end

  // system state register
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sys_reg <= '0;
    end
    else
    begin
      sys_reg <= sys_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign SDO_O            = frame_reg.sdo_lvl;
  assign SDO_OE_O         = frame_reg.sdo_oe;
  assign CFG_O            = sys_reg.cfg;
  assign CORE_SLEEP_O     = sys_reg.core_sleep;
  assign CH1_VALID_O      = sys_reg.ch1_valid;
  assign CH2_VALID_O      = sys_reg.ch2_valid;
  assign CH1_DATA_O       = sys_reg.ch1_data;
  assign CH2_DATA_O       = sys_reg.ch2_data;
  assign DRIVER_CURRENT_O = sys_reg.drv_cur;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  // cycles since channel 1 came up; starts saturated since reset is no nap
  logic [7:0] up1_cnt;
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      up1_cnt <= 8'hFF;
    end
    else if (sys_reg.cfg.nap_ch1 | sys_reg.core_sleep)
    begin
      up1_cnt <= 8'h00;
    end
    else if (up1_cnt != 8'hFF)
    begin
      up1_cnt <= up1_cnt + 8'h01;
    end
  end

  sequence s_read_fmt;
    frame_reg.cnt == ADDR_DONE_CNT && frame_reg.is_read
      && {frame_reg.shreg[5:0], SDI_I} == ADDR_FMT;
  endsequence

  property p_sdo_never_high;
    @(posedge SCK_I) disable iff (RST_I) SDO_O == 1'b0;
  endproperty
  a_sdo_never_high: assert property (p_sdo_never_high)
    else $error("sdo driven high");

  property p_extra_edges;
    @(posedge SCK_I) disable iff (RST_I)
      frame_reg.cnt == WORD_DONE_CNT |=> $stable(bank_reg);
  endproperty
  a_extra_edges: assert property (p_extra_edges)
    else $error("edge after sixteenth changed registers");

  property p_read_keeps;
    @(posedge SCK_I) disable iff (RST_I)
      frame_reg.cnt == LAST_BIT_CNT && frame_reg.is_read |=> $stable(bank_reg);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read command altered registers");

  property p_write_out;
    @(posedge SCK_I) disable iff (RST_I)
      frame_reg.cnt == LAST_BIT_CNT && !frame_reg.is_read
        && frame_reg.shreg[13:7] == ADDR_OUT
      |=> bank_reg.outc == {$past(frame_reg.shreg[6:0]), $past(SDI_I)};
  endproperty
  a_write_out: assert property (p_write_out)
    else $error("write data not stored");

  property p_soft_reset;
    @(posedge SCK_I) disable iff (RST_I)
      frame_reg.cnt == LAST_BIT_CNT && !frame_reg.is_read
        && frame_reg.shreg[13:7] == ADDR_RESET && frame_reg.shreg[6]
      |=> bank_reg.fmt == REG_RESET_VAL && bank_reg.outc == REG_RESET_VAL
        && bank_reg.pat_hi == REG_RESET_VAL && bank_reg.pat_lo == REG_RESET_VAL;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset left a register set");

  property p_read_msb_first;
    @(posedge SCK_I) disable iff (RST_I)
      s_read_fmt |=> (SDO_OE_O == ~$past(bank_reg.fmt[7]))
        ##1 (SDO_OE_O == ~$past(bank_reg.fmt[6], 2));
  endproperty
  a_read_msb_first: assert property (p_read_msb_first)
    else $error("read data order wrong");

  property p_reset_sleep;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      sys_reg.rst_s2 != sys_reg.rst_s3 |=> CORE_SLEEP_O [*8];
  endproperty
  a_reset_sleep: assert property (p_reset_sleep)
    else $error("no sleep after software reset");

  property p_pattern_wins;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      sys_reg.cfg.pattern_force_enable
      |=> CH1_DATA_O == {$past(sys_reg.cfg.pattern_high_byte),
                         $past(sys_reg.cfg.pattern_low_byte)};
  endproperty
  a_pattern_wins: assert property (p_pattern_wins)
    else $error("pattern did not override data");

  property p_signed;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      !sys_reg.cfg.pattern_force_enable && !sys_reg.cfg.output_scramble_enable
        && sys_reg.cfg.signed_format_select
      |=> CH2_DATA_O == {~$past(CH2_SAMPLE_I[15]), $past(CH2_SAMPLE_I[14:0])};
  endproperty
  a_signed: assert property (p_signed)
    else $error("two's complement coding wrong");

  property p_scramble;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      !sys_reg.cfg.pattern_force_enable && sys_reg.cfg.output_scramble_enable
        && !sys_reg.cfg.signed_format_select
      |=> CH1_DATA_O == {$past(CH1_SAMPLE_I[15:1]) ^ {15{$past(CH1_SAMPLE_I[0])}},
                         $past(CH1_SAMPLE_I[0])};
  endproperty
  a_scramble: assert property (p_scramble)
    else $error("scrambled data wrong");

  property p_nap_wake;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      $rose(CH1_VALID_O) |-> up1_cnt >= 8'(NAP_WAKE_CYC);
  endproperty
  a_nap_wake: assert property (p_nap_wake)
    else $error("channel valid too soon after nap");

  property p_term_double;
    @(posedge CLK_SYS_I) disable iff (RST_I)
      sys_reg.cfg.internal_term_enable && sys_reg.cfg.driver_current_code == 3'h4
      |=> DRIVER_CURRENT_O == {CUR_3P0[6:0], 1'b0};
  endproperty
  a_term_double: assert property (p_term_double)
    else $error("termination did not double current");

endmodule

// >>> core/ascp_pkg.sv
// shared constants and carriers of the serial configuration port
// assumes a 125 MHz system clock and a host-driven serial clock
package ascp_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_RESET  = 7'h00;
  localparam logic [6:0] ADDR_FMT    = 7'h01;
  localparam logic [6:0] ADDR_OUT    = 7'h02;
  localparam logic [6:0] ADDR_PAT_HI = 7'h03;
  localparam logic [6:0] ADDR_PAT_LO = 7'h04;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ---------------------------------------------------------------
  // command word layout and bit counter marks
  // ---------------------------------------------------------------
  localparam int         RW_POS        = 15;
  localparam int         ADDR_MSB      = 14;
  localparam int         ADDR_LSB      = 8;
  localparam logic [4:0] FIRST_BIT_CNT = 5'h00;
  localparam logic [4:0] ADDR_DONE_CNT = 5'h07;
  localparam logic [4:0] RD_LAST_CNT   = 5'h0E;
  localparam logic [4:0] LAST_BIT_CNT  = 5'h0F;
  localparam logic [4:0] WORD_DONE_CNT = 5'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SRST_BIT         = 7;
  localparam int FMT_DCS_OFF_BIT  = 7;
  localparam int FMT_SCRAMBLE_BIT = 6;
  localparam int FMT_SIGNED_BIT   = 5;
  localparam int FMT_SLEEP_BIT    = 4;
  localparam int FMT_NAP2_BIT     = 3;
  localparam int FMT_NAP1_BIT     = 0;
  localparam int OUT_CUR_MSB      = 7;
  localparam int OUT_CUR_LSB      = 5;
  localparam int OUT_TERM_BIT     = 4;
  localparam int OUT_OFF_BIT      = 3;
  localparam int OUT_TEST_BIT     = 2;
  localparam int OUT_LANE_MSB     = 1;
  localparam int OUT_LANE_LSB     = 0;

  // ---------------------------------------------------------------
  // driver current in units of 50 uA
  // ---------------------------------------------------------------
  localparam logic [7:0] CUR_1P75 = 8'h23;
  localparam logic [7:0] CUR_2P1  = 8'h2A;
  localparam logic [7:0] CUR_2P5  = 8'h32;
  localparam logic [7:0] CUR_3P0  = 8'h3C;
  localparam logic [7:0] CUR_3P5  = 8'h46;
  localparam logic [7:0] CUR_4P0  = 8'h50;
  localparam logic [7:0] CUR_4P5  = 8'h5A;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 8;
  localparam int         SRST_SLEEP_NS  = 200;
  localparam logic [7:0] SRST_SLEEP_CYC =
    8'((SRST_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] NAP_WAKE_CYC   = 7'h64;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       duty_stabilizer_off;
    logic       output_scramble_enable;
    logic       signed_format_select;
    logic       sleep_req;
    logic       nap_ch2;
    logic       nap_ch1;
    logic [2:0] driver_current_code;
    logic       internal_term_enable;
    logic       output_drivers_off;
    logic       pattern_force_enable;
    logic [1:0] lane_count_select;
    logic [7:0] pattern_high_byte;
    logic [7:0] pattern_low_byte;
  } ascp_cfg_s;

  typedef struct packed {
    logic [4:0]  cnt;
    logic [14:0] shreg;
    logic        is_read;
    logic [7:0]  rd_sh;
    logic        sdo_oe;
    logic        sdo_lvl;
  } ascp_frame_s;

  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] outc;
    logic [7:0] pat_hi;
    logic [7:0] pat_lo;
    logic       upd_tgl;
    logic       srst_tgl;
  } ascp_bank_s;

  typedef struct packed {
    logic        sel_s1;
    logic        sel_s2;
    logic        upd_s1;
    logic        upd_s2;
    logic        upd_s3;
    logic        rst_s1;
    logic        rst_s2;
    logic        rst_s3;
    ascp_cfg_s   cfg;
    logic [7:0]  sleep_cnt;
    logic [6:0]  nap1_cnt;
    logic [6:0]  nap2_cnt;
    logic        ch1_valid;
    logic        ch2_valid;
    logic [15:0] ch1_data;
    logic [15:0] ch2_data;
    logic        core_sleep;
    logic [7:0]  drv_cur;
  } ascp_sys_s;

endpackage

// >>> bench/ascp_host_model.sv
// host-side serial master model for the configuration port
// assumes the bench resolves the open-drain line with a pull-up
`timescale 1ns/1ns
module ascp_host_model
  (
    output logic      SCK_O,
    output logic      CS_N_O,
    output logic      SDI_O,
    input  wire logic SDO_I
  );
  // link clock stands still low outside frames
  initial
  begin
    SCK_O  = 1'b0;
    CS_N_O = 1'b1;
    SDI_O  = 1'b0;
  end
  // -------------------------------------------------------------
  // one frame of n edges, word left-aligned in w
  // -------------------------------------------------------------
  task automatic xfer(input logic [17:0] w, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #2; // keeps link edges off the system clock edges
    CS_N_O = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      SDI_O = w[17-k];
      #24 SCK_O = 1'b1;
      #24 SCK_O = 1'b0;
      // read bits stand edge to edge, so take them mid-period
      if (k >= 7 && k < 15)
      begin
        rd = {rd[6:0], SDO_I};
      end
    end
    SDI_O = ~SDI_O; // released data line does not hold its value
    #24 CS_N_O = 1'b1;
    #998; // gap lets the system side capture the write
  endtask
endmodule

// >>> bench/ascp_serial_port_test.sv
// self-checking bench of the serial configuration port
// assumes the host model drives the link and a pull-up on sdo
`timescale 1ns/1ns
module ascp_serial_port_test;
  import ascp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        par_sel = 1'b0;
  logic [15:0] s1 = 16'h0000;
  logic [15:0] s2 = 16'h0000;
  logic        sck, cs_n, sdi, sdo, sdo_oe, sdo_wire, core_sleep, v1, v2;
  logic [15:0] d1, d2;
  logic [7:0]  cur;
  logic [7:0]  rv;
  ascp_cfg_s   cfg;
  int          n_errors = 0;
  int          cmp_count = 0;
  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;
  assign sdo_wire = sdo_oe ? sdo : 1'b1; // pull-up wins when released
  ascp_host_model ascp_host_model_inst
    (.SCK_O(sck), .CS_N_O(cs_n), .SDI_O(sdi), .SDO_I(sdo_wire));
  ascp_serial_port ascp_serial_port_inst
    (.CLK_SYS_I(clk_sys), .RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .SDI_I(sdi),
     .SDO_I(sdo_wire), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
     .PARALLEL_SERIAL_SELECT_I(par_sel), .CH1_SAMPLE_I(s1), .CH2_SAMPLE_I(s2),
     .CFG_O(cfg), .CORE_SLEEP_O(core_sleep), .CH1_VALID_O(v1), .CH2_VALID_O(v2),
     .CH1_DATA_O(d1), .CH2_DATA_O(d2), .DRIVER_CURRENT_O(cur));
  // -------------------------------------------------------------
  // access and compare tasks
  // -------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
    ascp_host_model_inst.xfer({1'b0, a, d, 2'b11}, n, rv);
  endtask
  // sdi carries ones during the data half to show it is ignored
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    ascp_host_model_inst.xfer({1'b1, a, 8'hFF, 2'b11}, 16, rv);
    chk("readback", {8'h00, e}, {8'h00, rv});
  endtask
  task automatic sample(input logic [15:0] v);
    @(posedge clk_sys);
    s1 <= v;
    s2 <= v;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // -------------------------------------------------------------
  // main sequence; serial mode with select low until the final parallel-hold check
  // -------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    wr(ADDR_RESET, 8'h80, 16);
    wr(ADDR_FMT, 8'hA1, 16);
    wr(ADDR_OUT, 8'h91, 16);
    rd(ADDR_FMT, 8'hA1);
    rd(ADDR_FMT, 8'hA1);
    rd(ADDR_OUT, 8'h91);
    chk("current", 16'h0078, {8'h00, cur});
    chk("lanes", 16'h0001, {14'h0, cfg.lane_count_select});
    chk("dcs", 16'h0001, {15'h0, cfg.duty_stabilizer_off});
    chk("valids", 16'h0001, {14'h0, v1, v2});
    sample(16'h8001);
    chk("coding", 16'h0001, d2);
    chk("coding ch1", 16'h0001, d1);
    wr(ADDR_PAT_HI, 8'hA5, 10);
    wr(ADDR_PAT_LO, 8'h3C, 18);
    rd(ADDR_PAT_HI, 8'h00);
    rd(ADDR_PAT_LO, 8'h3C);
    wr(ADDR_PAT_HI, 8'h5A, 16);
    wr(ADDR_OUT, 8'h04, 16);
    chk("pattern", 16'h5A3C, d2);
    chk("pattern ch1", 16'h5A3C, d1);
    wr(ADDR_OUT, 8'h00, 16);
    wr(ADDR_FMT, 8'h40, 16);
    sample(16'h0003);
    chk("scramble", 16'hFFFD, d2);
    wr(ADDR_RESET, 8'h80, 16);
    rd(ADDR_FMT, 8'h00);
    rd(ADDR_RESET, 8'h00);
    wr(ADDR_OUT, 8'h08, 16);
    rd(ADDR_OUT, 8'h08);
    chk("drivers off", 16'h0001, {15'h0, cfg.output_drivers_off});
    chk("sdo level", 16'h0000, {15'h0, sdo});
    wr(ADDR_FMT, 8'h10, 16);
    chk("sleep", 16'h0001, {15'h0, core_sleep});
    chk("valids asleep", 16'h0000, {14'h0, v1, v2});
    // select high: a serial write must not reach the mode outputs
    @(posedge clk_sys);
    par_sel <= 1'b1;
    wr(ADDR_FMT, 8'h00, 16);
    chk("parallel hold", 16'h0001, {15'h0, core_sleep});
    report_and_stop();
  end
  // watchdog: the sequence needs about 37.5 us
  initial
  begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule
